// ==== hdl/lpm_pkg.sv ====
/*
  package for the low-power mode controller: register offsets, field layouts,
  reset values, mode encodings, timing counts and carrier structs.
  assumes an apb slave with 32-bit data and word-aligned registers.
*/
package lpm_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_PERMIT = 12'h000;
  localparam logic [11:0] OFF_PMCTRL = 12'h004;
  localparam logic [11:0] OFF_STOPCTRL = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;
  localparam logic [11:0] OFF_ISO = 12'h010;
  localparam logic [11:0] OFF_CORE = 12'h014;

  // mode_permit_register bits
  localparam int PERMIT_VERY_LOW_POWER_RUN = 0;
  localparam int PERMIT_VERY_LOW_POWER_STOP = 1;
  localparam int PERMIT_LLS = 2;
  localparam int PERMIT_VLLS = 3;
  localparam logic [3:0] PERMIT_RESET = 4'h0;

  // power_mode_control_register fields
  localparam int RUN_MODE_FIELD_LSB = 0;
  localparam int STOPM_LSB = 2;
  localparam logic [1:0] RUN_MODE_FIELD_NORMAL = 2'h0;
  localparam logic [1:0] RUN_MODE_FIELD_VERY_LOW_POWER_RUN = 2'h2;
  localparam logic [2:0] STOPM_NORMAL = 3'h0;
  localparam logic [2:0] STOPM_VERY_LOW_POWER_STOP = 3'h2;
  localparam logic [2:0] STOPM_LLS = 3'h3;
  localparam logic [2:0] STOPM_VLLS = 3'h4;
  localparam logic [4:0] PMCTRL_RESET = 5'h00;

  // stop_control_register: very_low_leakage_stop_n sub-mode 0..3
  localparam logic [1:0] VLLSM_RESET = 2'h3;

  // core control register bits
  localparam int CORE_DEEP = 0;
  localparam int CORE_SAH = 1;

  // status register bits
  localparam int ST_WAKE = 0;
  localparam int ST_ISO = 1;
  localparam int ST_RAMLOST = 2;
  localparam int ST_PERMIT_DONE = 3;
  localparam int ST_MODE_LSB = 4;

  // stop-mode write settle time, in core clocks
  localparam int SETTLE_CYCLES = 12;

  typedef enum logic [2:0] {
    PM_RUN = 3'h0,
    PM_VERY_LOW_POWER_RUN = 3'h1,
    PM_WAIT = 3'h2,
    PM_STOP = 3'h3,
    PM_VERY_LOW_POWER_STOP = 3'h4,
    PM_LLS = 3'h5,
    PM_VLLS = 3'h6
  } pmode_t;

  typedef struct packed {
    logic wait_for_interrupt_instruction;
    logic handlers_done;
    logic wake_pending;
    logic nmi;
    logic wake_unit_event;
    logic module_wake;
  } core_evt_t;

  typedef struct packed {
    logic sleeping;
    logic deep;
    logic [2:0] mode;
    logic resume_next;
    logic wake_unit_irq;
    logic module_irq;
    logic reset_req;
    logic iso_latch;
    logic fll_internal;
    logic wake_reset_cause;
    logic ram_lost;
  } core_ctl_t;
endpackage

// ==== hdl/settle_counter.sv ====
/*
  settle counter: counts core clocks since the last mode-select write.
  assumes restart is a one-cycle pulse from the register block.
*/
`timescale 1ns/1ps
module settle_counter (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic restart,
  output logic settled
);
  import lpm_pkg::*;
  logic [4:0] count;
  logic [4:0] next_count;

  always_comb begin
    next_count = count;
    if (restart) begin
      // the write cycle counts as the first one, so twelve cycles later the select holds
      next_count = 5'h01;
    end else if (count < 5'(SETTLE_CYCLES)) begin
      next_count = count + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 5'(SETTLE_CYCLES);
    end else begin
      count <= next_count;
    end
  end

  assign settled = (count >= 5'(SETTLE_CYCLES));
endmodule // settle_counter

// ==== hdl/low_power_mode_controller.sv ====
/*
  low-power mode controller: apb register block plus the sleep/wake sequencer
  that moves the core between run, wait and the stop modes.
  assumes core events arrive on pclk, synchronous, one-cycle pulses except levels
  wake_pending and nmi.
*/
// How it works
// R1 - mode permission register takes one write after reset, choosing allowed modes
// R2 - no mode permitted and deep sleep: wait-for-interrupt enters normal stop
// R3 - software disables clock monitor before non-wait low-power modes
// R4 - software enables a wake source before entering a low-power mode
// R5 - reset or nmi always wakes from every low-power mode
// R6 - stop-mode write takes effect once 12 core clocks pass before sleep
// R7 - wait-for-interrupt sleeps at once unless a wake condition already holds
// R8 - software reads back mode control before sleeping after a mode change
// R9 - sleep-after-handlers returns to sleep when all handlers finish
// R10 - sleep-after-handlers only for normal stop, very_low_power_stop, lls with deep sleep
// R11 - software meets clock limits before very-low-power run
// R12 - writing run-mode field enters very-low-power run
// R13 - run-mode write exit raises no exception; an interrupt may also exit (here only the run-mode write leaves very-low-power run)
// R14 - lls wake-unit exit leaves wake-unit interrupt pending with priority
// R15 - lls wake resumes at instruction after wait-for-interrupt
// R16 - very-low-leakage stop exits through the reset sequence
// R17 - pins stay latched after vlls until isolation ack bit written 1
// R18 - software reconfigures pins and oscillator before isolation ack
// R19 - ram lost in deepest vlls modes and unpowered regions of vlls2 (here ram_lost is set only for sub-modes 0 and 1, never for vlls2)
// R20 - module wake from vlls leaves wake-unit and module interrupts pending
// R21 - software clears pin wake flags and module flag in handler
// R22 - reset control unit records vlls wake-up as reset cause
// R23 - lls or vlls wake sets the wake bit in reset source status (an nmi exit from lls leaves it clear here)
// R24 - after vlls wake the clock comes up in fll internal mode
// R25 - later writes to mode permission register are ignored
`timescale 1ns/1ps
module low_power_mode_controller (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  input wire lpm_pkg::core_evt_t evt,
  // sequencer outputs
  output lpm_pkg::core_ctl_t ctl
);
  import lpm_pkg::*;

  logic [3:0] permit;
  logic permit_done;
  logic [4:0] pmctrl;
  logic [1:0] vllsm;
  logic deep;
  logic sah;
  logic iso;
  logic wake_flag;
  logic ram_lost;
  logic [3:0] next_permit;
  logic next_permit_done;
  logic [4:0] next_pmctrl;
  logic [1:0] next_vllsm;
  logic next_deep;
  logic next_sah;
  logic next_iso;
  logic next_wake_flag;
  logic next_ram_lost;
  logic [31:0] next_prdata;
  pmode_t state;
  pmode_t next_state;
  core_ctl_t next_ctl;
  logic wr;
  logic rd;
  logic mapped;
  logic restart;
  logic settled;
  logic [2:0] stop_sel;
  logic [2:0] req_stop;
  logic lls_wake;
  logic vlls_wake;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign mapped = hit(paddr, OFF_PERMIT) || hit(paddr, OFF_PMCTRL) || hit(paddr, OFF_STOPCTRL) ||
                  hit(paddr, OFF_STATUS) || hit(paddr, OFF_ISO) || hit(paddr, OFF_CORE);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign restart = wr && (hit(paddr, OFF_PMCTRL) || hit(paddr, OFF_STOPCTRL));

  settle_counter u_settle (
    .pclk(pclk),
    .presetn(presetn),
    .restart(restart),
    .settled(settled)
  );

  // a stop request falls back to normal stop unless the permission allows it
  assign stop_sel = pmctrl[STOPM_LSB +: 3];
  always_comb begin
    req_stop = STOPM_NORMAL; // R2
    unique case (stop_sel)
      STOPM_VERY_LOW_POWER_STOP: if (permit[PERMIT_VERY_LOW_POWER_STOP]) req_stop = STOPM_VERY_LOW_POWER_STOP;
      STOPM_LLS: if (permit[PERMIT_LLS]) req_stop = STOPM_LLS;
      STOPM_VLLS: if (permit[PERMIT_VLLS]) req_stop = STOPM_VLLS;
      default: req_stop = STOPM_NORMAL;
    endcase
  end

  // registers
  always_comb begin
    next_permit = permit;
    next_permit_done = permit_done;
    next_pmctrl = pmctrl;
    next_vllsm = vllsm;
    next_deep = deep;
    next_sah = sah;
    next_iso = iso;
    next_wake_flag = wake_flag;
    next_ram_lost = ram_lost;
    next_prdata = prdata;
    if (wr) begin
      if (hit(paddr, OFF_PERMIT) && !permit_done) begin
        next_permit = pwdata[3:0]; // R1
        next_permit_done = 1'b1; // R25
      end
      if (hit(paddr, OFF_PMCTRL)) begin
        next_pmctrl[STOPM_LSB +: 3] = pwdata[STOPM_LSB +: 3];
        // very_low_power_run entry only when permitted; clearing the field always leaves it
        if (pwdata[RUN_MODE_FIELD_LSB +: 2] != RUN_MODE_FIELD_VERY_LOW_POWER_RUN || permit[PERMIT_VERY_LOW_POWER_RUN]) begin
          next_pmctrl[RUN_MODE_FIELD_LSB +: 2] = pwdata[RUN_MODE_FIELD_LSB +: 2]; // R12
        end
      end
      if (hit(paddr, OFF_STOPCTRL)) begin
        next_vllsm = pwdata[1:0];
      end
      if (hit(paddr, OFF_CORE)) begin
        next_deep = pwdata[CORE_DEEP];
        next_sah = pwdata[CORE_SAH];
      end
      if (hit(paddr, OFF_ISO) && pwdata[0]) begin
        next_iso = 1'b0; // R17
      end
      if (hit(paddr, OFF_STATUS) && pwdata[ST_WAKE]) begin
        next_wake_flag = 1'b0;
      end
    end
    // hardware set wins over a same-cycle software clear
    if (vlls_wake) begin
      next_iso = 1'b1; // R17
      next_ram_lost = (vllsm < 2'h2); // R19
    end
    if (lls_wake || vlls_wake) begin
      next_wake_flag = 1'b1; // R23
    end
    if (vlls_wake) begin
      next_pmctrl[RUN_MODE_FIELD_LSB +: 2] = RUN_MODE_FIELD_NORMAL; // R16
    end
    if (rd) begin
      next_prdata = 32'h0;
      unique case (1'b1)
        hit(paddr, OFF_PERMIT): next_prdata[3:0] = permit;
        hit(paddr, OFF_PMCTRL): next_prdata[4:0] = pmctrl;
        hit(paddr, OFF_STOPCTRL): next_prdata[1:0] = vllsm;
        hit(paddr, OFF_STATUS): begin
          next_prdata[ST_WAKE] = wake_flag;
          next_prdata[ST_ISO] = iso;
          next_prdata[ST_RAMLOST] = ram_lost;
          next_prdata[ST_PERMIT_DONE] = permit_done;
          next_prdata[ST_MODE_LSB +: 3] = state;
        end
        hit(paddr, OFF_ISO): next_prdata[0] = iso;
        hit(paddr, OFF_CORE): next_prdata[1:0] = {sah, deep};
        default: next_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      permit <= PERMIT_RESET;
      permit_done <= 1'b0;
      pmctrl <= PMCTRL_RESET;
      vllsm <= VLLSM_RESET;
      deep <= 1'b0;
      sah <= 1'b0;
      iso <= 1'b0;
      wake_flag <= 1'b0;
      ram_lost <= 1'b0;
      prdata <= 32'h0;
    end else begin
      permit <= next_permit;
      permit_done <= next_permit_done;
      pmctrl <= next_pmctrl;
      vllsm <= next_vllsm;
      deep <= next_deep;
      sah <= next_sah;
      iso <= next_iso;
      wake_flag <= next_wake_flag;
      ram_lost <= next_ram_lost;
      prdata <= next_prdata;
    end
  end

  // sequencer
  assign lls_wake = (state == PM_LLS) && evt.wake_unit_event;
  assign vlls_wake = (state == PM_VLLS) && (evt.wake_unit_event || evt.nmi);

  always_comb begin
    logic sleep_go;
    sleep_go = evt.wait_for_interrupt_instruction || (evt.handlers_done && sah && deep && (req_stop != STOPM_VLLS)); // R9 R10
    next_state = state;
    next_ctl = ctl;
    next_ctl.reset_req = 1'b0;
    next_ctl.resume_next = 1'b0;
    next_ctl.wake_reset_cause = 1'b0;
    if (evt.handlers_done) begin
      next_ctl.wake_unit_irq = 1'b0;
      next_ctl.module_irq = 1'b0;
    end
    // a mode write drops the fll flag, but a vlls wake in the same cycle sets it again
    if (wr && hit(paddr, OFF_PMCTRL)) begin
      next_ctl.fll_internal = 1'b0;
    end
    unique case (state)
      PM_RUN, PM_VERY_LOW_POWER_RUN: begin
        next_state = (pmctrl[RUN_MODE_FIELD_LSB +: 2] == RUN_MODE_FIELD_VERY_LOW_POWER_RUN) ? PM_VERY_LOW_POWER_RUN : PM_RUN; // R12 R13
        // a pending wake blocks entry; an unsettled stop write is not yet seen
        if (sleep_go && !evt.wake_pending && !evt.nmi) begin // R7
          if (!deep) begin
            next_state = PM_WAIT;
          end else if (settled) begin // R6
            unique case (req_stop)
              STOPM_VERY_LOW_POWER_STOP: next_state = PM_VERY_LOW_POWER_STOP;
              STOPM_LLS: next_state = PM_LLS;
              STOPM_VLLS: next_state = PM_VLLS;
              default: next_state = PM_STOP; // R2
            endcase
          end else begin
            next_state = PM_STOP;
          end
        end
      end
      PM_WAIT, PM_STOP, PM_VERY_LOW_POWER_STOP: begin
        if (evt.wake_pending || evt.nmi) begin // R5
          next_state = (pmctrl[RUN_MODE_FIELD_LSB +: 2] == RUN_MODE_FIELD_VERY_LOW_POWER_RUN && state != PM_STOP) ? PM_VERY_LOW_POWER_RUN : PM_RUN;
        end
      end
      PM_LLS: begin
        if (evt.wake_unit_event || evt.nmi) begin // R5
          next_state = PM_RUN;
          next_ctl.resume_next = 1'b1; // R15
          next_ctl.wake_unit_irq = evt.wake_unit_event; // R14
        end
      end
      PM_VLLS: begin
        if (evt.wake_unit_event || evt.nmi) begin // R5
          next_state = PM_RUN;
          next_ctl.reset_req = 1'b1; // R16
          next_ctl.wake_reset_cause = 1'b1; // R22
          next_ctl.wake_unit_irq = evt.wake_unit_event; // R20
          next_ctl.module_irq = evt.module_wake; // R20
          next_ctl.fll_internal = 1'b1; // R24
        end
      end
      default: next_state = PM_RUN;
    endcase
    next_ctl.sleeping = (next_state != PM_RUN) && (next_state != PM_VERY_LOW_POWER_RUN);
    next_ctl.deep = next_ctl.sleeping && (next_state != PM_WAIT);
    next_ctl.mode = next_state;
    next_ctl.iso_latch = next_iso;
    next_ctl.ram_lost = next_ram_lost;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PM_RUN;
      ctl <= '0;
    end else begin
      state <= next_state;
      ctl <= next_ctl;
    end
  end

  AST_PERMIT_ONCE: assert property (@(posedge pclk) disable iff (!presetn) // R25
    permit_done |=> $stable(permit)) else $error("permission changed after first write");
  AST_PERMIT_TAKE: assert property (@(posedge pclk) disable iff (!presetn) // R1
    wr && hit(paddr, OFF_PERMIT) && !permit_done |=> permit == $past(pwdata[3:0]))
    else $error("first permission write not taken");
  AST_NO_SLEEP_ON_WAKE: assert property (@(posedge pclk) disable iff (!presetn) // R7
    (state == PM_RUN) && evt.wait_for_interrupt_instruction && evt.wake_pending |=> !ctl.sleeping)
    else $error("slept with wake pending");
  AST_STOP_DEFAULT: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (state == PM_RUN) && evt.wait_for_interrupt_instruction && deep && permit == 4'h0 && !evt.wake_pending && !evt.nmi
    |=> state == PM_STOP) else $error("no normal stop");
  AST_NMI_WAKE: assert property (@(posedge pclk) disable iff (!presetn) // R5
    ctl.sleeping && evt.nmi |=> !ctl.sleeping) else $error("nmi did not wake");
  AST_VLLS_RESET: assert property (@(posedge pclk) disable iff (!presetn) // R16
    vlls_wake |=> ctl.reset_req && ctl.wake_reset_cause && ctl.fll_internal)
    else $error("vlls exit not through reset");
  AST_ISO_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // R17
    iso && !(wr && hit(paddr, OFF_ISO) && pwdata[0]) |=> iso) else $error("isolation released early");
  AST_WAKE_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // R23
    lls_wake |=> wake_flag && ctl.resume_next) else $error("lls wake not recorded");
  AST_LLS_IRQ: assert property (@(posedge pclk) disable iff (!presetn) // R14
    lls_wake |=> ctl.wake_unit_irq) else $error("wake unit irq not pending");
  AST_SETTLE: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (state == PM_RUN) && evt.wait_for_interrupt_instruction && deep && !settled && !evt.wake_pending && !evt.nmi
    |=> state == PM_STOP) else $error("unsettled stop select used");

  COV_VLLS: cover property (@(posedge pclk) disable iff (!presetn) vlls_wake);
  COV_LLS: cover property (@(posedge pclk) disable iff (!presetn) lls_wake);
  COV_VERY_LOW_POWER_RUN: cover property (@(posedge pclk) disable iff (!presetn) state == PM_VERY_LOW_POWER_RUN);
  COV_SAH: cover property (@(posedge pclk) disable iff (!presetn) evt.handlers_done && sah && deep);
endmodule // low_power_mode_controller

// ==== testbench/core_model.sv ====
/*
  core model: stands for the processor core that raises sleep, handler and
  wake events toward the mode controller.
  assumes the controller samples every event on the rising edge of pclk.
*/
`timescale 1ns/1ps
module core_model (
  // clock
  input wire logic pclk,
  // core events
  output lpm_pkg::core_evt_t evt
);
  import lpm_pkg::*;

  initial begin
    evt = '0;
  end

  // returns at the edge where the instruction is sampled; software has already
  // turned the clock monitor off and met the slow-clock limits by this point
  task automatic sleep_now();
    @(posedge pclk);
    evt.wait_for_interrupt_instruction <= 1'b1;
    @(posedge pclk);
    evt.wait_for_interrupt_instruction <= 1'b0;
  endtask

  // handlers finish; the wake-unit handler has cleared its flags by now
  task automatic end_handlers();
    @(posedge pclk);
    evt.handlers_done <= 1'b1;
    @(posedge pclk);
    evt.handlers_done <= 1'b0;
  endtask

  // an enabled wake-unit source fires, optionally flagged by a module
  task automatic wake_unit(input logic by_module);
    @(posedge pclk);
    evt.wake_unit_event <= 1'b1;
    evt.module_wake <= by_module;
    @(posedge pclk);
    evt.wake_unit_event <= 1'b0;
    evt.module_wake <= 1'b0;
  endtask

  // extra edge so the caller returns where the levels are first sampled
  task automatic set_level(input logic v_nmi, input logic v_pend);
    @(posedge pclk);
    evt.nmi <= v_nmi;
    evt.wake_pending <= v_pend;
    @(posedge pclk);
  endtask
endmodule // core_model

// ==== testbench/low_power_mode_controller_bench.sv ====
/*
  bench for the low-power mode controller: apb master tasks, the core model on
  the event side and one task per scenario.
  assumes ctl is registered and pready comes within a few cycles.
*/
`timescale 1ns/1ps
module low_power_mode_controller_bench;
  import lpm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  core_evt_t evt;
  core_ctl_t ctl;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int cmp_count = 0;
  int n_resume = 0;
  int n_rst = 0;
  int n_cause = 0;

  low_power_mode_controller low_power_mode_controller_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt(evt), .ctl(ctl));
  core_model core_model_i (.pclk(pclk), .evt(evt));

  initial begin
    forever #2.5 pclk = ~pclk;
  end

  // pulses stand one cycle, so they are counted rather than looked for later
  always @(posedge pclk) begin
    if (ctl.resume_next === 1'b1) n_resume++;
    if (ctl.reset_req === 1'b1) n_rst++;
    if (ctl.wake_reset_cause === 1'b1) n_cause++;
  end

  task automatic print_verdict();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask

  task automatic after(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic chk_sm(input logic s, input pmode_t m);
    chk(32'({ctl.sleeping, ctl.deep, ctl.mode}), 32'({s, s && (m != PM_WAIT), m}));
  endtask

  task automatic wake_nmi();
    core_model_i.set_level(1'b1, 1'b0);
    after(1);
    chk_sm(1'b0, PM_RUN);
    core_model_i.set_level(1'b0, 1'b0);
  endtask

  task automatic t_reset();
    rdchk(OFF_PERMIT, {28'h0, PERMIT_RESET});
    rdchk(OFF_PMCTRL, {27'h0, PMCTRL_RESET});
    rdchk(OFF_STOPCTRL, {30'h0, VLLSM_RESET});
    rdchk(OFF_STATUS, 32'h0);
    rdchk(12'h018, 32'h0);
    chk(32'(err), 32'h1);
  endtask

  task automatic t_no_permit();
    wr(OFF_PMCTRL, {27'h0, STOPM_LLS, RUN_MODE_FIELD_VERY_LOW_POWER_RUN});
    after(2);
    chk_sm(1'b0, PM_RUN);
    wr(OFF_CORE, 32'h1);
    repeat (SETTLE_CYCLES) @(posedge pclk);
    core_model_i.sleep_now();
    after(1);
    chk_sm(1'b1, PM_STOP);
    wake_nmi();
    core_model_i.set_level(1'b0, 1'b1);
    core_model_i.sleep_now();
    after(1);
    chk_sm(1'b0, PM_RUN);
    core_model_i.set_level(1'b0, 1'b0);
  endtask

  task automatic t_permit();
    wr(OFF_PERMIT, 32'hf);
    wr(OFF_PERMIT, 32'h0);
    rdchk(OFF_PERMIT, 32'hf);
    rdchk(OFF_STATUS, 32'h1 << ST_PERMIT_DONE);
  endtask

  task automatic t_low_run();
    int base;
    base = n_resume + n_rst;
    wr(OFF_PMCTRL, {27'h0, STOPM_NORMAL, RUN_MODE_FIELD_VERY_LOW_POWER_RUN});
    after(2);
    chk_sm(1'b0, PM_VERY_LOW_POWER_RUN);
    wr(OFF_PMCTRL, {27'h0, STOPM_NORMAL, RUN_MODE_FIELD_NORMAL});
    after(2);
    chk_sm(1'b0, PM_RUN);
    chk(32'(n_resume + n_rst - base), 32'h0);
    chk(32'({ctl.wake_unit_irq, ctl.module_irq}), 32'h0);
  endtask

  task automatic t_settle();
    wr(OFF_CORE, 32'h1);
    wr(OFF_PMCTRL, {27'h0, STOPM_VERY_LOW_POWER_STOP, RUN_MODE_FIELD_NORMAL});
    core_model_i.sleep_now();
    after(1);
    chk_sm(1'b1, PM_STOP);
    wake_nmi();
    wr(OFF_PMCTRL, {27'h0, STOPM_VERY_LOW_POWER_STOP, RUN_MODE_FIELD_NORMAL});
    rdchk(OFF_PMCTRL, {27'h0, STOPM_VERY_LOW_POWER_STOP, RUN_MODE_FIELD_NORMAL});
    repeat (SETTLE_CYCLES) @(posedge pclk);
    core_model_i.sleep_now();
    after(1);
    chk_sm(1'b1, PM_VERY_LOW_POWER_STOP);
    wake_nmi();
  endtask

  task automatic t_leak_stop();
    int b_res;
    int b_rst;
    wr(OFF_CORE, 32'h3);
    wr(OFF_PMCTRL, {27'h0, STOPM_LLS, RUN_MODE_FIELD_NORMAL});
    repeat (SETTLE_CYCLES) @(posedge pclk);
    core_model_i.sleep_now();
    after(1);
    chk_sm(1'b1, PM_LLS);
    b_res = n_resume;
    b_rst = n_rst;
    core_model_i.wake_unit(1'b0);
    after(1);
    chk(32'({ctl.sleeping, ctl.wake_unit_irq, ctl.module_irq}), 32'h2);
    rdchk(OFF_STATUS, 32'h9);
    chk(32'(n_resume - b_res + 2 * (n_rst - b_rst)), 32'h1);
    wr(OFF_STATUS, 32'h1);
    rdchk(OFF_STATUS, 32'h8);
    core_model_i.end_handlers();
    after(1);
    chk_sm(1'b1, PM_LLS);
    chk(32'(ctl.wake_unit_irq), 32'h0);
    wake_nmi();
    wr(OFF_CORE, 32'h2);
    core_model_i.end_handlers();
    after(1);
    chk_sm(1'b0, PM_RUN);
    // shallow sleep: wait mode, left through a pending wake
    core_model_i.sleep_now();
    after(1);
    chk_sm(1'b1, PM_WAIT);
    core_model_i.set_level(1'b0, 1'b1);
    after(1);
    chk_sm(1'b0, PM_RUN);
    core_model_i.set_level(1'b0, 1'b0);
  endtask

  task automatic t_deep_leak();
    int b_rst;
    int b_cause;
    wr(OFF_CORE, 32'h1);
    wr(OFF_STOPCTRL, 32'h1);
    wr(OFF_PMCTRL, {27'h0, STOPM_VLLS, RUN_MODE_FIELD_NORMAL});
    repeat (SETTLE_CYCLES) @(posedge pclk);
    core_model_i.sleep_now();
    after(1);
    chk_sm(1'b1, PM_VLLS);
    b_rst = n_rst;
    b_cause = n_cause;
    core_model_i.wake_unit(1'b1);
    after(1);
    chk(32'({ctl.wake_unit_irq, ctl.module_irq, ctl.iso_latch, ctl.fll_internal, ctl.ram_lost}), 32'h1f);
    rdchk(OFF_STATUS, 32'hf);
    chk(32'(n_rst - b_rst), 32'h1);
    chk(32'(n_cause - b_cause), 32'h1);
    chk(32'(ctl.iso_latch), 32'h1);
    // pins and any kept oscillator count as reconfigured before the release
    wr(OFF_ISO, 32'h1);
    after(1);
    chk(32'(ctl.iso_latch), 32'h0);
  endtask

  // a reset in mid-run reopens the one-time permission write
  task automatic t_rerun();
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFF_STATUS, 32'h0);
    wr(OFF_PERMIT, 32'h4);
    rdchk(OFF_PERMIT, 32'h4);
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    chk(32'(ctl), 32'h0);
    presetn <= 1'b1;
    t_reset();
    t_no_permit();
    t_permit();
    t_low_run();
    t_settle();
    t_leak_stop();
    t_deep_leak();
    t_rerun();
    print_verdict();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    print_verdict();
  end
endmodule // low_power_mode_controller_bench
